// ---- afx_ctrl.sv ----
// Controller driving a chain of asynchronous 9-bit FIFOs through their pins
// Functional notes
// [R1] Exactly one chain device has first load low
// [R2] All other chain devices hold first load high
// [R3] Each expansion output feeds next expansion input
// [R4] Composite full and empty are ORs of flags
// [R5] No rewind or half flag in depth mode
// [R6] Width mode: common controls, status from one
// [R7] Read flow-through presents word after write edge
// [R8] Flow-through empty flag pulses then reasserts
// [R9] Write flow-through: full drops, stored on rise
// [R10] Write strobe toggled only while not full
// [R11] Single reset zeroes pointers, sets flags
// [R12] Rewind returns read pointer, write untouched
// [R13] Pointers advance only when flag allows
// [R14] Depth reset zeroes pointers on every device
// [R15] Expansion output pulses at last location
// [R16] Grounded expansion input selects single mode
// [R17] Strobes stay high during a rewind
// [R18] Only the token holder accepts strobes
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "afx_consts.svh"
module afx_ctrl #(
	parameter int NDEV = 3,  // Devices on the depth chain
	parameter int DW   = 9   // Word width per device
) (
	input  wire logic            clock,
	input  wire logic            rst_b,
	input  wire logic [3:0]      addr,
	input  wire logic [31:0]     wdata,
	input  wire logic            wr_en,
	input  wire logic            rd_en,
	output logic      [31:0]     rdata,
	output logic                 irq,
	output logic                 write_strobe_n,
	output logic                 read_strobe_n,
	output logic                 pointer_clear_n,
	output logic      [NDEV-1:0] first_load_select_n,
	output logic      [DW-1:0]   fifo_wdata,
	input  wire logic [DW-1:0]   fifo_rdata,
	input  wire logic [NDEV-1:0] no_words_flag_n,
	input  wire logic [NDEV-1:0] no_space_flag_n,
	input  wire logic            half_level_flag_n
);
	localparam int EW = `AFX_EV_W;
	localparam int SW = 2 * NDEV + 1 + DW;  // Synchronised pin bundle width
	// Cycle counts, least times rounded up; access gets 3 cycles more
	localparam int STROBE_CYC = (`AFX_T_STROBE_NS + `AFX_CLK_NS - 1) / `AFX_CLK_NS;
	localparam int ACCESS_CYC = (`AFX_T_ACCESS_NS + `AFX_CLK_NS - 1) / `AFX_CLK_NS + 3;
	localparam int RECOV_CYC  = (`AFX_T_RECOV_NS + `AFX_CLK_NS - 1) / `AFX_CLK_NS;
	localparam int RESET_CYC  = (`AFX_T_RESET_NS + `AFX_CLK_NS - 1) / `AFX_CLK_NS;
	localparam logic [7:0] STROBE_LD = 8'(STROBE_CYC - 1);
	localparam logic [7:0] ACCESS_LD = 8'(ACCESS_CYC - 1);
	localparam logic [7:0] RECOV_LD  = 8'(RECOV_CYC - 1);
	localparam logic [7:0] RESET_LD  = 8'(RESET_CYC - 1);
	// First device low, all others high
	localparam logic [NDEV-1:0] FL_DEPTH = ~NDEV'(1);

	afx_pkg::afx_state_t state_q;  // Sequencer state
	afx_pkg::afx_state_t state_d;
	logic [7:0]      cnt_q;        // Phase length counter
	logic [7:0]      cnt_d;
	logic            depth_q;      // Chain runs in depth expansion
	logic            depth_d;
	logic [DW-1:0]   wword_q;      // Word driven to the FIFOs
	logic [DW-1:0]   rword_q;      // Last word read back
	logic [EW-1:0]   int_stat_q;   // Sticky events
	logic [EW-1:0]   int_stat_d;
	logic [EW-1:0]   int_en_q;     // Event enables
	logic [EW-1:0]   int_en_d;
	logic            words_p_q;    // Previous words-available
	logic            space_p_q;    // Previous space-available
	logic            w_n_q;
	logic            r_n_q;
	logic            rs_n_q;
	logic [NDEV-1:0] fl_n_q;
	logic [31:0]     rdata_q;
	logic            irq_q;
	logic [SW-1:0]   pins_s;       // Synchronised flags and data
	logic            ev_wr;
	logic            ev_rd;
	logic            ev_rst;

	// Flags and read data arrive from another timing world
	afx_sync #(.W(SW)) u_sync (
		.clock (clock),
		.rst_b (rst_b),
		.din   ({half_level_flag_n, no_space_flag_n, no_words_flag_n, fifo_rdata}),
		.dout  (pins_s)
	);

	wire [DW-1:0]   q_s     = pins_s[DW-1:0];
	wire [NDEV-1:0] ef_s    = pins_s[DW +: NDEV];
	wire [NDEV-1:0] ff_s    = pins_s[DW + NDEV +: NDEV];
	wire            hf_s    = pins_s[SW-1];
	// Composite flags in depth mode, device zero alone otherwise
	wire words_ok = depth_q ? |ef_s : ef_s[0];  // R3 R4 R6
	wire space_ok = depth_q ? |ff_s : ff_s[0];  // R4 R6
	// Half flag is meaningless on a chain, so it is masked there
	wire half_on  = ~hf_s & ~depth_q;           // R5

	// Command decode
	wire idle      = (state_q == afx_pkg::AFX_IDLE);
	wire wr_ctrl   = wr_en && (addr == `AFX_REG_CTRL);
	wire go_reset  = wr_ctrl && wdata[`AFX_CTRL_RESET];
	wire go_rewind = wr_ctrl && wdata[`AFX_CTRL_REWIND];
	wire go_read   = wr_ctrl && wdata[`AFX_CTRL_READ];
	wire go_write  = wr_en && (addr == `AFX_REG_WDATA);
	wire ok_reset  = idle && go_reset;
	wire ok_rewind = idle && go_rewind && !go_reset && !depth_q;           // R5
	wire ok_read   = idle && go_read && !go_reset && !go_rewind && words_ok;
	wire ok_write  = idle && go_write && space_ok;                         // R10
	wire refused   = (go_reset || go_rewind || go_read || go_write)
	                 && !(ok_reset || ok_rewind || ok_read || ok_write);
	wire cnt_zero  = (cnt_q == 8'h00);
	wire [EW-1:0] clr_mask = (wr_en && addr == `AFX_REG_INT_CLR) ? wdata[EW-1:0] : '0;
	wire [EW-1:0] events;

	// Sequencer next state; one command at a time, refused while busy
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_zero ? cnt_q : cnt_q - 8'h01;
		ev_wr   = 1'b0;
		ev_rd   = 1'b0;
		ev_rst  = 1'b0;
		case (state_q)
			afx_pkg::AFX_IDLE: begin
				if (ok_reset) begin
					state_d = afx_pkg::AFX_RST_LO;
					cnt_d   = RESET_LD;
				end else if (ok_rewind) begin
					state_d = afx_pkg::AFX_RT_LO;
					cnt_d   = STROBE_LD;
				end else if (ok_read) begin
					state_d = afx_pkg::AFX_RD_LO;
					cnt_d   = ACCESS_LD;
				end else if (ok_write) begin
					state_d = afx_pkg::AFX_WR_LO;
					cnt_d   = STROBE_LD;
				end
			end
			afx_pkg::AFX_RST_LO: begin
				if (cnt_zero) begin
					state_d = afx_pkg::AFX_RST_HI;
					cnt_d   = RECOV_LD;
				end
			end
			afx_pkg::AFX_WR_LO: begin
				if (cnt_zero) begin
					state_d = afx_pkg::AFX_WR_HI;
					cnt_d   = RECOV_LD;
				end
			end
			afx_pkg::AFX_RD_LO: begin
				if (cnt_zero) begin
					state_d = afx_pkg::AFX_RD_HI;
					cnt_d   = RECOV_LD;
				end
			end
			afx_pkg::AFX_RT_LO: begin
				if (cnt_zero) begin
					state_d = afx_pkg::AFX_RT_HI;
					cnt_d   = RECOV_LD;
				end
			end
			// Recovery phases end in idle; reset, write and read report their event, rewind none
			afx_pkg::AFX_RST_HI,
			afx_pkg::AFX_WR_HI,
			afx_pkg::AFX_RD_HI,
			afx_pkg::AFX_RT_HI: begin
				if (cnt_zero) begin
					state_d = afx_pkg::AFX_IDLE;
					ev_rst  = (state_q == afx_pkg::AFX_RST_HI);
					ev_wr   = (state_q == afx_pkg::AFX_WR_HI);
					ev_rd   = (state_q == afx_pkg::AFX_RD_HI);
				end
			end
			default: begin
				state_d = afx_pkg::AFX_IDLE;
				cnt_d   = 8'h00;
			end
		endcase
	end

	// Mode only moves while idle, so pins never change mid-cycle
	assign depth_d = (wr_ctrl && idle) ? wdata[`AFX_CTRL_DEPTH] : depth_q;
	// Filters and flags settle during a device reset; drops there are no events
	wire   in_reset = (state_q == afx_pkg::AFX_RST_LO) || (state_q == afx_pkg::AFX_RST_HI);
	assign events  = {ev_rst, words_p_q & ~words_ok & ~in_reset,
	                  space_p_q & ~space_ok & ~in_reset, refused, ev_rd, ev_wr};
	// A new event beats a clear in the same cycle
	assign int_stat_d = (int_stat_q & ~clr_mask) | events;
	assign int_en_d   = (wr_en && addr == `AFX_REG_INT_EN) ? wdata[EW-1:0] : int_en_q;

	// Pin levels derived from the next state so they align with it
	wire            w_n_d  = (state_d != afx_pkg::AFX_WR_LO);   // R10
	wire            r_n_d  = (state_d != afx_pkg::AFX_RD_LO);
	wire            rs_n_d = (state_d != afx_pkg::AFX_RST_LO);
	// Chain: one first device; single: the shared pin is the rewind
	wire [NDEV-1:0] fl_n_d = depth_d ? FL_DEPTH                 // R1 R2
	                         : ((state_d == afx_pkg::AFX_RT_LO) ? '0 : '1);
	wire [31:0]     status = {27'h0, depth_q, half_on, space_ok, words_ok, ~idle};

	// Register read mux
	wire [31:0] rd_mux =
		(addr == `AFX_REG_CTRL)     ? {31'h0, depth_q} :
		(addr == `AFX_REG_WDATA)    ? {{(32-DW){1'b0}}, wword_q} :
		(addr == `AFX_REG_RDATA)    ? {{(32-DW){1'b0}}, rword_q} :
		(addr == `AFX_REG_STATUS)   ? status :
		(addr == `AFX_REG_INT_STAT) ? {{(32-EW){1'b0}}, int_stat_q} :
		(addr == `AFX_REG_INT_EN)   ? {{(32-EW){1'b0}}, int_en_q} : 32'h0000_0000;

	// Sequencer and mode; power-up starts with a device reset
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= afx_pkg::AFX_RST_LO;
			cnt_q   <= RESET_LD;
			depth_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			depth_q <= depth_d;
		end
	end

	// Pins; strobes stay high through reset and rewind
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			w_n_q  <= 1'b1;
			r_n_q  <= 1'b1;
			rs_n_q <= 1'b0;
			fl_n_q <= '1;
		end else begin
			w_n_q  <= w_n_d;
			r_n_q  <= r_n_d;
			rs_n_q <= rs_n_d;
			fl_n_q <= fl_n_d;    // R17
		end
	end

	// Data words; read word latched at end of the access phase
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wword_q <= '0;
			rword_q <= '0;
		end else begin
			if (ok_write)
				wword_q <= wdata[DW-1:0];
			if (state_q == afx_pkg::AFX_RD_LO && cnt_zero)
				rword_q <= q_s;
		end
	end

	// Interrupt registers, edge history and read port
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			int_stat_q <= '0;
			int_en_q   <= `AFX_INT_EN_RST;
			words_p_q  <= 1'b0;
			space_p_q  <= 1'b0;
			rdata_q    <= `AFX_RDATA_RST;
			irq_q      <= 1'b0;
		end else begin
			int_stat_q <= int_stat_d;
			int_en_q   <= int_en_d;
			words_p_q  <= words_ok;
			space_p_q  <= space_ok;
			rdata_q    <= rd_en ? rd_mux : 32'h0000_0000;
			irq_q      <= |(int_stat_d & int_en_d);
		end
	end

	assign write_strobe_n      = w_n_q;
	assign read_strobe_n       = r_n_q;
	assign pointer_clear_n     = rs_n_q;
	assign first_load_select_n = fl_n_q;
	assign fifo_wdata          = wword_q;
	assign rdata               = rdata_q;
	assign irq                 = irq_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_write_low;
		!w_n_q [*5];
	endsequence
	sequence s_write_recover;
		w_n_q [*6];
	endsequence

	a_depth_first_load: assert property ((depth_q && $past(depth_q)) |-> // R1 R2
		(fl_n_q == FL_DEPTH && $countones(~fl_n_q) == 1))
		else $error("first load pattern wrong in depth mode");
	a_write_needs_space: assert property ($fell(w_n_q) |-> $past(space_ok)) // R10
		else $error("write strobe fell while chain was full");
	a_write_strobe_shape: assert property ($fell(w_n_q) |-> // R10
		s_write_low ##1 s_write_recover)
		else $error("write strobe width or recovery wrong");
	a_rewind_strobes_high: assert property ((!depth_q && !fl_n_q[0]) |-> // R17
		(w_n_q && r_n_q && rs_n_q))
		else $error("strobe low during rewind");
	a_composite_full: assert property ((depth_q && !in_reset && $fell(space_ok)) |-> // R4
		(ff_s == '0) ##1 int_stat_q[`AFX_EV_FULL])
		else $error("composite full raised with a device not full");
	a_width_single_status: assert property (!depth_q |-> // R6
		(words_ok == ef_s[0] && space_ok == ff_s[0]))
		else $error("width mode status not from device zero");
	a_rewind_refused_depth: assert property ((depth_q && idle && go_rewind && !go_reset // R5
		&& wdata[`AFX_CTRL_DEPTH]) |->
		##1 (fl_n_q == FL_DEPTH && int_stat_q[`AFX_EV_REFUSED]))
		else $error("rewind in depth mode not refused");
	a_reset_strobes: assert property ($fell(rs_n_q) |-> // R14
		(!rs_n_q && w_n_q && r_n_q) [*8])
		else $error("reset pulse too short or strobe low");
	a_no_strobe_overlap: assert property (!(!w_n_q && !r_n_q)) // R13
		else $error("read and write strobes low together");
endmodule // afx_ctrl

// ---- afx_consts.svh ----
// Offsets, field positions, reset values and timing figures of the FIFO chain controller
`ifndef AFX_CONSTS_SVH
`define AFX_CONSTS_SVH
// Register word indices on the command port
`define AFX_REG_CTRL      4'h0
`define AFX_REG_WDATA     4'h1
`define AFX_REG_RDATA     4'h2
`define AFX_REG_STATUS    4'h3
`define AFX_REG_INT_STAT  4'h4
`define AFX_REG_INT_CLR   4'h5
`define AFX_REG_INT_EN    4'h6
// Control register fields
`define AFX_CTRL_DEPTH    0
`define AFX_CTRL_RESET    1
`define AFX_CTRL_REWIND   2
`define AFX_CTRL_READ     3
// Status register fields
`define AFX_ST_BUSY       0
`define AFX_ST_WORDS      1
`define AFX_ST_SPACE      2
`define AFX_ST_HALF       3
`define AFX_ST_DEPTH      4
// Event bits of the interrupt registers
`define AFX_EV_WR_DONE    0
`define AFX_EV_RD_DONE    1
`define AFX_EV_REFUSED    2
`define AFX_EV_FULL       3
`define AFX_EV_EMPTY      4
`define AFX_EV_RST_DONE   5
`define AFX_EV_W          6
// Reset values
`define AFX_INT_EN_RST    6'h00
`define AFX_RDATA_RST     32'h0000_0000
// Timing figures in ns
`define AFX_CLK_NS        4
`define AFX_T_STROBE_NS   20
`define AFX_T_ACCESS_NS   20
`define AFX_T_RECOV_NS    24
`define AFX_T_RESET_NS    40
`endif

// ---- afx_pkg.sv ----
// Types of the FIFO chain controller
package afx_pkg;
	// One-hot sequencer states
	typedef enum logic [8:0] {
		AFX_IDLE   = 9'h001,
		AFX_RST_LO = 9'h002,
		AFX_RST_HI = 9'h004,
		AFX_WR_LO  = 9'h008,
		AFX_WR_HI  = 9'h010,
		AFX_RD_LO  = 9'h020,
		AFX_RD_HI  = 9'h040,
		AFX_RT_LO  = 9'h080,
		AFX_RT_HI  = 9'h100
	} afx_state_t;
endpackage

// ---- afx_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module afx_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_q;   // Metastable stage, read only by s2
	logic [W-1:0] s2_q;   // Second stage
	logic [W-1:0] s3_q;   // Third stage
	logic [W-1:0] out_q;  // Filtered value
	wire  [W-1:0] agree = ~(s2_q ^ s3_q);  // Bits whose last two stages match

	// Shift chain; a bit moves only once stages two and three agree
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s1_q  <= '1;
			s2_q  <= '1;
			s3_q  <= '1;
			out_q <= '1;
		end else begin
			s1_q  <= din;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= (s2_q & agree) | (out_q & ~agree);
		end
	end
	assign dout = out_q;
endmodule // afx_sync

// ---- afx_fifo_model.sv ----
// Behavioural chain of asynchronous 9-bit FIFO devices
`timescale 1ns/1ps
module afx_fifo_model #(
	parameter int NDEV  = 3, // Devices on the chain
	parameter int DEPTH = 4, // Words per device, small so full is reached
	parameter int ACC   = 8  // Read access delay in ns
) (
	input  wire logic            depth_mode,
	input  wire logic            write_strobe_n,
	input  wire logic            read_strobe_n,
	input  wire logic            pointer_clear_n,
	input  wire logic [NDEV-1:0] first_load_select_n,
	input  wire logic [8:0]      fifo_wdata,
	output logic      [8:0]      fifo_rdata,
	output logic      [NDEV-1:0] no_words_flag_n,
	output logic      [NDEV-1:0] no_space_flag_n,
	output logic                 half_level_flag_n
);
	logic [8:0]      mem [NDEV][DEPTH]; // Storage
	int              wp [NDEV];         // Write pointers
	int              rp [NDEV];         // Read pointers
	int              cnt [NDEV];        // Fill levels
	logic [NDEV-1:0] wtok = '0;         // Write token holders
	logic [NDEV-1:0] rtok = '0;         // Read token holders
	logic [NDEV-1:0] wgo  = '0;         // Write cycle accepted
	logic [NDEV-1:0] rgo  = '0;         // Read cycle accepted
	logic [8:0]      word;              // Word under read
	initial fifo_rdata = 9'h0A5;
	// Level acting reset and rewind; single mode runs all devices in step
	always @(pointer_clear_n or first_load_select_n) begin
		for (int i = 0; i < NDEV; i++) begin
			if (!pointer_clear_n) begin
				wp[i] = 0;
				rp[i] = 0;
				cnt[i] = 0;
				wtok = depth_mode ? ~first_load_select_n : '1;
				rtok = wtok;
			end else if (!depth_mode && !first_load_select_n[0]) begin
				rp[i] = 0;
				cnt[i] = wp[i];
			end
		end
	end
	// Write taken on fall only with space and token, stored on rise
	always @(negedge write_strobe_n)
		for (int i = 0; i < NDEV; i++) wgo[i] = wtok[i] && cnt[i] < DEPTH;
	always @(posedge write_strobe_n) begin
		for (int i = 0; i < NDEV; i++) if (wgo[i]) begin
			mem[i][wp[i]] = fifo_wdata;
			cnt[i]++;
			wp[i] = (wp[i] + 1) % DEPTH;
			// Token moves on once the last location is used
			if (depth_mode && wp[i] == 0) wtok = {wtok[NDEV-2:0], wtok[NDEV-1]};
		end
		// Read held low on an empty chain shows the new word ACC ns after the write rise
		if (!read_strobe_n && rgo == 0)
			for (int i = 0; i < NDEV; i++) if (rtok[i] && cnt[i] > 0) begin
				rgo[i] = 1'b1;
				fifo_rdata <= #ACC mem[i][rp[i]];
			end
		wgo = '0;
	end
	// Read taken on fall only with data and token
	always @(negedge read_strobe_n) begin
		for (int i = NDEV - 1; i >= 0; i--) begin
			rgo[i] = rtok[i] && cnt[i] > 0;
			if (rgo[i]) word = mem[i][rp[i]];
		end
		if (rgo != 0) fifo_rdata <= #ACC word;
	end
	// Released bus shows no stale word
	always @(posedge read_strobe_n) begin
		fifo_rdata = ~fifo_rdata;
		for (int i = 0; i < NDEV; i++) if (rgo[i]) begin
			cnt[i]--;
			rp[i] = (rp[i] + 1) % DEPTH;
			if (depth_mode && rp[i] == 0) rtok = {rtok[NDEV-2:0], rtok[NDEV-1]};
		end
		rgo = '0;
		// A write held low on a full device is taken once this read frees space
		if (!write_strobe_n && wgo == 0)
			for (int i = 0; i < NDEV; i++) wgo[i] = wtok[i] && cnt[i] < DEPTH;
	end
	// Flags, half flag silent in depth mode
	always_comb begin
		for (int i = 0; i < NDEV; i++) begin
			no_words_flag_n[i] = cnt[i] != 0;
			no_space_flag_n[i] = cnt[i] != DEPTH;
		end
		half_level_flag_n = depth_mode || cnt[0] <= DEPTH / 2;
	end
endmodule // afx_fifo_model

// ---- testbench.sv ----
// Self-checking bench of the FIFO chain controller
`timescale 1ns/1ps
`include "afx_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
	localparam int NDEV  = 3;
	localparam int DEPTH = 4;
	logic            clock = 1'b0;
	logic            rst_b = 1'b0;
	logic [3:0]      addr  = 4'h0;
	logic [31:0]     wdata = 32'h0;
	logic            wr_en = 1'b0;
	logic            rd_en = 1'b0;
	logic            dmode = 1'b0; // Chain wiring of the model
	logic [31:0]     rdata;
	logic [31:0]     v;
	logic            irq;
	logic            write_strobe_n;
	logic            read_strobe_n;
	logic            pointer_clear_n;
	logic            half_level_flag_n;
	logic [NDEV-1:0] first_load_select_n;
	logic [NDEV-1:0] no_words_flag_n;
	logic [NDEV-1:0] no_space_flag_n;
	logic [8:0]      fifo_wdata;
	logic [8:0]      fifo_rdata;
	logic [8:0]      q[$];    // Words expected out
	logic [8:0]      hist[$]; // Copy kept for the replay
	int              n_errors = 0;
	int              checks = 0;
	int              cyc = 0;
	afx_ctrl #(.NDEV(NDEV), .DW(9)) u_dut (.clock, .rst_b, .addr, .wdata, .wr_en, .rd_en,
		.rdata, .irq, .write_strobe_n, .read_strobe_n, .pointer_clear_n, .first_load_select_n,
		.fifo_wdata, .fifo_rdata, .no_words_flag_n, .no_space_flag_n, .half_level_flag_n);
	afx_fifo_model #(.NDEV(NDEV), .DEPTH(DEPTH), .ACC(8)) u_fifo (.depth_mode(dmode),
		.write_strobe_n, .read_strobe_n, .pointer_clear_n, .first_load_select_n, .fifo_wdata,
		.fifo_rdata, .no_words_flag_n, .no_space_flag_n, .half_level_flag_n);
	always #2 clock = ~clock;
	// Expected status word
	function automatic logic [31:0] st(input logic w, input logic s, input logic h);
		st = 32'h0;
		st[`AFX_ST_WORDS] = w;
		st[`AFX_ST_SPACE] = s;
		st[`AFX_ST_HALF] = h;
		st[`AFX_ST_DEPTH] = dmode;
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic bw(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic br(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask
	// Bounded poll of the busy bit, ends on a status read
	task automatic idle();
		repeat (40) begin
			br(`AFX_REG_STATUS);
			if (v[`AFX_ST_BUSY] === 1'b0) return;
		end
		`CHK("busy", 1'b0, v[`AFX_ST_BUSY]);
	endtask
	task automatic cmd(input int b);
		bw(`AFX_REG_CTRL, {31'h0, dmode} | (32'h1 << b));
		idle();
	endtask
	task automatic push(input bit keep);
		logic [8:0] w;
		w = 9'($urandom);
		if (keep) q.push_back(w);
		bw(`AFX_REG_WDATA, {23'h0, w});
		idle();
	endtask
	task automatic pop();
		logic [8:0] x;
		x = q.pop_front();
		cmd(`AFX_CTRL_READ);
		br(`AFX_REG_RDATA);
		`CHK("word", {23'h0, x}, v);
	endtask
	task automatic refused(input int b);
		bw(`AFX_REG_INT_CLR, 32'h3F);
		cmd(b);
		br(`AFX_REG_INT_STAT);
		`CHK("refused", 1'b1, v[`AFX_EV_REFUSED]);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(32'h83f1));
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		idle();
		`CHK("status", st(0, 1, 0), v);
		br(`AFX_REG_INT_STAT);
		`CHK("int_stat", 32'h1 << `AFX_EV_RST_DONE, v);
		`CHK("fl", {NDEV{1'b1}}, first_load_select_n);
		$display("test power-up done");
		// Three words, two out, rewind, replay all three
		repeat (3) push(1);
		hist = q;
		br(`AFX_REG_STATUS);
		`CHK("status", st(1, 1, 1), v);
		pop();
		pop();
		cmd(`AFX_CTRL_REWIND);
		q = hist;
		repeat (3) pop();
		refused(`AFX_CTRL_READ);
		$display("test rewind done");
		// Fill to the brim, one more refused, drain
		cmd(`AFX_CTRL_RESET);
		repeat (DEPTH) push(1);
		br(`AFX_REG_STATUS);
		`CHK("status", st(1, 0, 1), v);
		bw(`AFX_REG_INT_CLR, 32'h3F);
		push(0);
		br(`AFX_REG_INT_STAT);
		`CHK("refused", 1'b1, v[`AFX_EV_REFUSED]);
		repeat (DEPTH) pop();
		$display("test full done");
		// Interrupt masked, enabled, cleared; unmapped index reads zero
		bw(`AFX_REG_INT_CLR, 32'h3F);
		push(1);
		`CHK("irq", 1'b0, irq);
		bw(`AFX_REG_INT_EN, 32'h1 << `AFX_EV_WR_DONE);
		repeat (2) @(posedge clock);
		`CHK("irq", 1'b1, irq);
		bw(`AFX_REG_INT_CLR, 32'h1 << `AFX_EV_WR_DONE);
		repeat (2) @(posedge clock);
		`CHK("irq", 1'b0, irq);
		br(4'hB);
		`CHK("unmapped", 32'h0, v);
		$display("test irq done");
		// Depth chain: token walks all devices, no rewind
		dmode <= 1'b1;
		q.delete();
		bw(`AFX_REG_CTRL, 32'h3);
		idle();
		`CHK("status", st(0, 1, 0), v);
		`CHK("fl", {{(NDEV-1){1'b1}}, 1'b0}, first_load_select_n);
		repeat (NDEV * DEPTH) push(1);
		br(`AFX_REG_STATUS);
		`CHK("status", st(1, 0, 0), v);
		refused(`AFX_CTRL_REWIND);
		repeat (NDEV * DEPTH) pop();
		br(`AFX_REG_STATUS);
		`CHK("status", st(0, 1, 0), v);
		$display("test depth done");
		wrap_up();
	end
endmodule // testbench
